// ---- tcb_capture_edge.sv ----
// Purpose: Capture input conditioning: sync, optional filter, edge detect.
// Assumes: Both trigger inputs are asynchronous to pclk.
// Notes: Filter adds FILTER_SAMPLES+1 cycles of delay when enabled.
`timescale 1ns/1ps
module tcb_capture_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic capture_pin,
    input wire logic comparator_in,
    input wire tcb_pkg::tcb_cap_cfg_t cfg,
    output logic capture_evt
);
    logic [1:0] sync_pin;
    logic [1:0] sync_comp;
    logic [tcb_pkg::FILTER_SAMPLES-1:0] samples;
    logic filtered;
    logic level;
    logic level_d;
    logic src;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_pin <= 2'h0;
            sync_comp <= 2'h0;
        end else begin
            sync_pin <= {sync_pin[0], capture_pin};
            sync_comp <= {sync_comp[0], comparator_in};
        end
    end

    assign src = cfg.source_comp ? sync_comp[1] : sync_pin[1];

    // Filtered level moves only when all samples agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samples <= '0;
            filtered <= 1'b0;
        end else begin
            samples <= {samples[tcb_pkg::FILTER_SAMPLES-2:0], src};
            if (&samples) begin
                filtered <= 1'b1;
            end else if (~|samples) begin
                filtered <= 1'b0;
            end
        end
    end

    assign level = cfg.noise_cancel ? filtered : src;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_d <= 1'b0;
            capture_evt <= 1'b0;
        end else begin
            level_d <= level;
            capture_evt <= cfg.enable && (level != level_d)
                && (level == cfg.rising);
        end
    end

endmodule : tcb_capture_edge

// ---- tcb_cpu_bus.sv ----
// Purpose: CPU-side bus master model driving the timer over APB.
// Assumes: Caller is single-threaded, so no interrupt can split a pair.
// Notes: Each wait is bounded; a missing answer raises hung.
`timescale 1ns/1ps
module tcb_cpu_bus (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic hung
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        hung = 1'b0;
    end
    // One byte per transfer in bits 7:0 of the 32-bit data path
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        // Blocking, so the caller's very next check already sees a timeout
        if (pready !== 1'b1) hung = 1'b1;
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // High byte first, then the committing low byte
    task automatic put16(input logic [7:0] a, input logic [15:0] v);
        logic [7:0] q;
        logic e;
        xfer(1'b1, a + 8'h04, v[15:8], q, e);
        xfer(1'b1, a, v[7:0], q, e);
    endtask : put16
    // Low byte first so the high byte is latched coherently
    task automatic get16(input logic [7:0] a, output logic [15:0] v);
        logic e;
        xfer(1'b0, a, 8'h00, v[7:0], e);
        xfer(1'b0, a + 8'h04, 8'h00, v[15:8], e);
    endtask : get16
endmodule : tcb_cpu_bus

// ---- tcb_pkg.sv ----
// Purpose: Shared constants and types for the 16-bit timer core.
// Assumes: APB3 slave with 32-bit data, one byte register per word.
// Notes: Byte registers sit in bits 7:0; upper bits read as zero.
package tcb_pkg;

    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int PRESC_W = 10;

    // Byte addresses of the register locations
    localparam logic [ADDR_W-1:0] OFF_COUNT_LO = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COUNT_HI = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CMPA_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CMPA_HI = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CMPB_LO = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CMPB_HI = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CAPT_LO = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CAPT_HI = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_CTRL_A = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_CTRL_B = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_POWER = 8'h30;

    // Count limits
    localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] TOP_8BIT = 16'h00FF;
    localparam logic [CNT_W-1:0] TOP_9BIT = 16'h01FF;
    localparam logic [CNT_W-1:0] TOP_10BIT = 16'h03FF;

    // Flag and mask bit positions
    localparam int BIT_OVF = 0;
    localparam int BIT_MATCH_A = 1;
    localparam int BIT_MATCH_B = 2;
    localparam int BIT_CAPT = 3;
    localparam int N_FLAGS = 4;

    // Control A fields
    localparam int CA_MODE_LO = 0;
    localparam int CA_CAPT_SRC = 2;
    localparam int CA_OUT_B_EN = 4;
    localparam int CA_OUT_A_EN = 6;
    // Control B fields, then the power register bit
    localparam int CB_CS_LO = 0;
    localparam int CB_MODE_HI = 3;
    localparam int CB_EDGE_RISE = 6;
    localparam int CB_NOISE_CANCEL = 7;
    localparam int BIT_POWER_REDUCE = 0;

    localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
    localparam int FILTER_SAMPLES = 4;

    // Prescaler tap widths: /8, /64, /256, /1024
    localparam int DIV8_W = 3;
    localparam int DIV64_W = 6;
    localparam int DIV256_W = 8;
    localparam int DIV1024_W = 10;

    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } tcb_clk_sel_t;

    typedef enum logic [1:0] {
        TOP_FIXED = 2'b00,
        TOP_FROM_A = 2'b01,
        TOP_FROM_CAPT = 2'b10,
        TOP_FULL = 2'b11
    } tcb_top_src_t;

    typedef struct packed {
        logic source_comp;
        logic noise_cancel;
        logic rising;
        logic enable;
    } tcb_cap_cfg_t;

    typedef struct packed {
        tcb_top_src_t src;
        logic [CNT_W-1:0] fixed;
        logic pwm;
    } tcb_top_t;

endpackage : tcb_pkg

// ---- tcb_timer16.sv ----
// Purpose: 16-bit timer core with byte-wide register access over APB.
// Assumes: One pclk domain; timer pins are asynchronous and synchronised.
// Notes: Up-counting only; detailed waveform modes live elsewhere.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module tcb_timer16 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_pin,
    input wire logic capture_pin,
    input wire logic comparator_in,
    output logic irq_req,
    output logic compare_a_out,
    output logic compare_b_out
);
    localparam int W = tcb_pkg::CNT_W;
    localparam int B = tcb_pkg::BYTE_W;

    logic [W-1:0] count_value;
    logic [W-1:0] compare_a_value;
    logic [W-1:0] compare_b_value;
    logic [W-1:0] compare_a_buf;
    logic [W-1:0] compare_b_buf;
    logic [W-1:0] capture_value;
    logic [B-1:0] hold;
    logic [B-1:0] control_a_reg;
    logic [B-1:0] control_b_reg;
    logic [tcb_pkg::N_FLAGS-1:0] irq_flag_reg;
    logic [tcb_pkg::N_FLAGS-1:0] irq_mask_reg;
    logic power_reduce_bit;
    logic [tcb_pkg::PRESC_W-1:0] presc;
    logic [2:0] ext_sync;
    logic timer_tick;
    logic capture_evt;
    logic wr_done;
    logic rd_take;
    logic [B-1:0] wbyte;
    logic [B-1:0] rbyte;
    logic mapped;
    logic [3:0] mode;
    tcb_pkg::tcb_top_t top_cfg;
    logic [W-1:0] top_value;
    logic at_top;
    logic match_a;
    logic match_b;
    tcb_pkg::tcb_clk_sel_t clock_select_field;
    tcb_pkg::tcb_cap_cfg_t cap_cfg;

    // Bus handshake: one wait state, write commits at the completing edge
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_take = psel && penable && !pready && !pwrite;
    assign wbyte = pwdata[B-1:0];

    always_comb begin
        mapped = 1'b1;
        rbyte = tcb_pkg::RESET_BYTE;
        case (paddr)
            tcb_pkg::OFF_COUNT_LO: rbyte = count_value[B-1:0];
            tcb_pkg::OFF_COUNT_HI: rbyte = hold;
            tcb_pkg::OFF_CMPA_LO: rbyte = compare_a_buf[B-1:0];
            tcb_pkg::OFF_CMPA_HI: rbyte = compare_a_buf[W-1:B];
            tcb_pkg::OFF_CMPB_LO: rbyte = compare_b_buf[B-1:0];
            tcb_pkg::OFF_CMPB_HI: rbyte = compare_b_buf[W-1:B];
            tcb_pkg::OFF_CAPT_LO: rbyte = capture_value[B-1:0];
            tcb_pkg::OFF_CAPT_HI: rbyte = hold;
            tcb_pkg::OFF_CTRL_A: rbyte = control_a_reg;
            tcb_pkg::OFF_CTRL_B: rbyte = control_b_reg;
            tcb_pkg::OFF_FLAG: rbyte = {4'h0, irq_flag_reg};
            tcb_pkg::OFF_MASK: rbyte = {4'h0, irq_mask_reg};
            tcb_pkg::OFF_POWER: rbyte = {7'h00, power_reduce_bit};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (rd_take) begin
                prdata <= {24'h00_0000, rbyte};
            end
        end
    end

    // Shared holding byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= tcb_pkg::RESET_BYTE;
        end else if (wr_done && (paddr == tcb_pkg::OFF_COUNT_HI
                || paddr == tcb_pkg::OFF_CMPA_HI
                || paddr == tcb_pkg::OFF_CMPB_HI
                || paddr == tcb_pkg::OFF_CAPT_HI)) begin
            hold <= wbyte;
        end else if (rd_take && paddr == tcb_pkg::OFF_COUNT_LO) begin
            hold <= count_value[W-1:B];
        end else if (rd_take && paddr == tcb_pkg::OFF_CAPT_LO) begin
            hold <= capture_value[W-1:B];
        end
    end

    // Byte control registers, mask and power bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_a_reg <= tcb_pkg::RESET_BYTE;
            control_b_reg <= tcb_pkg::RESET_BYTE;
            irq_mask_reg <= '0;
            power_reduce_bit <= 1'b0;
        end else if (wr_done) begin
            case (paddr)
                tcb_pkg::OFF_CTRL_A: control_a_reg <= wbyte;
                tcb_pkg::OFF_CTRL_B: control_b_reg <= wbyte;
                tcb_pkg::OFF_MASK:
                    irq_mask_reg <= wbyte[tcb_pkg::N_FLAGS-1:0];
                tcb_pkg::OFF_POWER:
                    power_reduce_bit <= wbyte[tcb_pkg::BIT_POWER_REDUCE];
                default: ;
            endcase
        end
    end

    assign mode = {control_b_reg[tcb_pkg::CB_MODE_HI +: 2],
        control_a_reg[tcb_pkg::CA_MODE_LO +: 2]};
    assign clock_select_field =
        tcb_pkg::tcb_clk_sel_t'(control_b_reg[tcb_pkg::CB_CS_LO +: 3]);

    // Mode to top-source decode
    always_comb begin
        top_cfg.pwm = 1'b1;
        top_cfg.fixed = tcb_pkg::CNT_MAX;
        top_cfg.src = tcb_pkg::TOP_FIXED;
        case (mode)
            4'h1, 4'h5: top_cfg.fixed = tcb_pkg::TOP_8BIT;
            4'h2, 4'h6: top_cfg.fixed = tcb_pkg::TOP_9BIT;
            4'h3, 4'h7: top_cfg.fixed = tcb_pkg::TOP_10BIT;
            4'h4: begin
                top_cfg.src = tcb_pkg::TOP_FROM_A;
                top_cfg.pwm = 1'b0;
            end
            4'h9, 4'hB, 4'hF: top_cfg.src = tcb_pkg::TOP_FROM_A;
            4'h8, 4'hA, 4'hE: top_cfg.src = tcb_pkg::TOP_FROM_CAPT;
            4'hC: begin
                top_cfg.src = tcb_pkg::TOP_FROM_CAPT;
                top_cfg.pwm = 1'b0;
            end
            default: begin
                top_cfg.src = tcb_pkg::TOP_FULL;
                top_cfg.pwm = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (top_cfg.src)
            tcb_pkg::TOP_FROM_A: top_value = compare_a_value;
            tcb_pkg::TOP_FROM_CAPT: top_value = capture_value;
            tcb_pkg::TOP_FIXED: top_value = top_cfg.fixed;
            default: top_value = tcb_pkg::CNT_MAX;
        endcase
    end

    // Wrap at top, and always at max so a top below count cannot stall
    assign at_top = (count_value == top_value)
        || (count_value == tcb_pkg::CNT_MAX);

    // Clock select: prescaler taps or synchronised external edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= '0;
            ext_sync <= 3'h0;
        end else begin
            presc <= power_reduce_bit ? '0 : presc + 1'b1;
            ext_sync <= {ext_sync[1:0], ext_clock_pin};
        end
    end

    always_comb begin
        case (clock_select_field)
            tcb_pkg::CS_DIV1: timer_tick = 1'b1;
            tcb_pkg::CS_DIV8: timer_tick = &presc[tcb_pkg::DIV8_W-1:0];
            tcb_pkg::CS_DIV64: timer_tick = &presc[tcb_pkg::DIV64_W-1:0];
            tcb_pkg::CS_DIV256: timer_tick = &presc[tcb_pkg::DIV256_W-1:0];
            tcb_pkg::CS_DIV1024:
                timer_tick = &presc[tcb_pkg::DIV1024_W-1:0];
            tcb_pkg::CS_EXT_FALL: timer_tick = ext_sync[2] && !ext_sync[1];
            tcb_pkg::CS_EXT_RISE: timer_tick = !ext_sync[2] && ext_sync[1];
            default: timer_tick = 1'b0;
        endcase
        if (power_reduce_bit) begin
            timer_tick = 1'b0;
        end
    end

    // Counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= tcb_pkg::CNT_BOTTOM;
        end else if (wr_done && paddr == tcb_pkg::OFF_COUNT_LO) begin
            count_value <= {hold, wbyte};
        end else if (timer_tick) begin
            count_value <= at_top ? tcb_pkg::CNT_BOTTOM
                : count_value + 1'b1;
        end
    end

    // Compare buffers; PWM modes move them to the active copy at bottom
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_buf <= '0;
            compare_b_buf <= '0;
            compare_a_value <= '0;
            compare_b_value <= '0;
        end else begin
            if (wr_done && paddr == tcb_pkg::OFF_CMPA_LO) begin
                compare_a_buf <= {hold, wbyte};
            end
            if (wr_done && paddr == tcb_pkg::OFF_CMPB_LO) begin
                compare_b_buf <= {hold, wbyte};
            end
            if (!top_cfg.pwm
                    || count_value == tcb_pkg::CNT_BOTTOM) begin
                compare_a_value <= compare_a_buf;
                compare_b_value <= compare_b_buf;
            end
        end
    end

    assign match_a = timer_tick && (count_value == compare_a_value);
    assign match_b = timer_tick && (count_value == compare_b_value);

    assign cap_cfg.source_comp = control_a_reg[tcb_pkg::CA_CAPT_SRC];
    assign cap_cfg.noise_cancel = control_b_reg[tcb_pkg::CB_NOISE_CANCEL];
    assign cap_cfg.rising = control_b_reg[tcb_pkg::CB_EDGE_RISE];
    assign cap_cfg.enable = !power_reduce_bit
        && (top_cfg.src != tcb_pkg::TOP_FROM_CAPT);

    tcb_capture_edge u_capture (
        .pclk(pclk),
        .presetn(presetn),
        .capture_pin(capture_pin),
        .comparator_in(comparator_in),
        .cfg(cap_cfg),
        .capture_evt(capture_evt)
    );

    // Capture register; writable only while it serves as top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value <= '0;
        end else if (capture_evt) begin
            capture_value <= count_value;
        end else if (wr_done && paddr == tcb_pkg::OFF_CAPT_LO
                && top_cfg.src == tcb_pkg::TOP_FROM_CAPT) begin
            capture_value <= {hold, wbyte};
        end
    end

    // Flags: write one to clear, a same-cycle event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_reg <= '0;
        end else begin
            if (wr_done && paddr == tcb_pkg::OFF_FLAG) begin
                irq_flag_reg <= irq_flag_reg
                    & ~wbyte[tcb_pkg::N_FLAGS-1:0];
            end
            if (timer_tick && at_top) begin
                irq_flag_reg[tcb_pkg::BIT_OVF] <= 1'b1;
            end
            if (match_a) begin
                irq_flag_reg[tcb_pkg::BIT_MATCH_A] <= 1'b1;
            end
            if (match_b) begin
                irq_flag_reg[tcb_pkg::BIT_MATCH_B] <= 1'b1;
            end
            if (capture_evt) begin
                irq_flag_reg[tcb_pkg::BIT_CAPT] <= 1'b1;
            end
        end
    end

    // Request and compare outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 1'b0;
            compare_a_out <= 1'b0;
            compare_b_out <= 1'b0;
        end else begin
            irq_req <= |(irq_flag_reg & irq_mask_reg);
            if (top_cfg.pwm) begin
                compare_a_out <= control_a_reg[tcb_pkg::CA_OUT_A_EN]
                    && (top_cfg.src != tcb_pkg::TOP_FROM_A)
                    && (count_value < compare_a_value);
                compare_b_out <= control_a_reg[tcb_pkg::CA_OUT_B_EN]
                    && (count_value < compare_b_value);
            end else begin
                if (match_a && control_a_reg[tcb_pkg::CA_OUT_A_EN]) begin
                    compare_a_out <= !compare_a_out;
                end
                if (match_b && control_a_reg[tcb_pkg::CA_OUT_B_EN]) begin
                    compare_b_out <= !compare_b_out;
                end
            end
        end
    end

endmodule : tcb_timer16

// ---- tcb_timer16_properties.sv ----
// Purpose: Port-level checks of the timer core bus and interrupt line.
// Assumes: One pclk domain, asynchronous active-low reset.
// Notes: Sees only the top module's ports; bound after the module.
`timescale 1ns/1ps
module tcb_timer16_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_answer_timing: assert property (s_access |=> s_answer)
        else $error("answer not exactly one cycle after access");
    a_no_stray: assert property (!(psel && penable) |=> !pready)
        else $error("answer without an access");
    a_error_paired: assert property (pslverr |-> pready)
        else $error("error flag without answer");
    a_unmapped_error: assert property (
        (psel && penable && !pready && paddr > 8'h30) |=> pslverr)
        else $error("unmapped access not refused");
    a_unmapped_zero: assert property (
        (psel && penable && !pready && !pwrite && paddr > 8'h30)
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_mapped_ok: assert property (
        (psel && penable && !pready && paddr <= 8'h30 && paddr[1:0] == 2'b00)
        |=> !pslverr)
        else $error("mapped access refused");
    a_byte_wide: assert property (prdata[31:8] == 24'h00_0000)
        else $error("read data above byte lane");
    a_data_holds: assert property (
        !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
        else $error("read data changed without a read");
    a_mask_off: assert property (
        (psel && penable && !pready && pwrite
        && paddr == tcb_pkg::OFF_MASK && pwdata[3:0] == 4'h0)
        |-> ##[1:4] !irq_req)
        else $error("request stays with all masks clear");
    a_reset_quiet: assert property ($rose(presetn) |-> !pready && !irq_req)
        else $error("outputs active at reset release");
endmodule : tcb_timer16_properties

bind tcb_timer16 tcb_timer16_properties chk_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req));

// ---- test_tcb_timer16.sv ----
// Purpose: Self-checking bench for the timer core.
// Assumes: Bus model answers within its bound.
// Notes: Timing-dependent counts are checked as ranges.
`timescale 1ns/1ps
module test_tcb_timer16;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
    logic ext_clock_pin, capture_pin, irq_req, e, comp_in, out_a, out_b;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata;
    logic [15:0] v;
    int errors, cmp_count;
    tcb_timer16 uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
        .comparator_in(comp_in), .irq_req(irq_req), .compare_a_out(out_a),
        .compare_b_out(out_b));
    tcb_cpu_bus bus (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung(hung));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task close_out;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp || hung !== 1'b0) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
        if (hung !== 1'b0) close_out();
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus.xfer(1'b1, a, d, b, e);
    endtask : wr
    task rd(input logic [7:0] a);
        bus.xfer(1'b0, a, 8'h00, b, e);
    endtask : rd
    task t_reset;
        bus.get16(tcb_pkg::OFF_COUNT_LO, v);
        chk("count", 16'h0000, v);
        bus.get16(tcb_pkg::OFF_CMPB_LO, v);
        chk("cmp_b", 16'h0000, v);
        rd(tcb_pkg::OFF_FLAG);
        chk("flags", 16'h0000, {8'h00, b});
    endtask : t_reset
    task t_shared;
        bus.put16(tcb_pkg::OFF_CMPA_LO, 16'h5511);
        wr(tcb_pkg::OFF_CMPB_LO, 8'h22);
        bus.put16(tcb_pkg::OFF_COUNT_LO, 16'h1234);
        wr(tcb_pkg::OFF_COUNT_HI, 8'h77);
        rd(tcb_pkg::OFF_COUNT_HI);
        chk("hold", 16'h0077, {8'h00, b});
        repeat (20) @(posedge pclk);
        rd(tcb_pkg::OFF_COUNT_LO);
        chk("count_lo", 16'h0034, {8'h00, b});
        bus.get16(tcb_pkg::OFF_CMPA_LO, v);
        chk("cmp_a", 16'h5511, v);
        rd(tcb_pkg::OFF_COUNT_HI);
        chk("count_hi", 16'h0012, {8'h00, b});
        bus.get16(tcb_pkg::OFF_CMPB_LO, v);
        chk("cmp_b", 16'h5522, v);
    endtask : t_shared
    task t_run;
        bus.put16(tcb_pkg::OFF_CMPA_LO, 16'h0003);
        bus.put16(tcb_pkg::OFF_CMPB_LO, 16'h0005);
        bus.put16(tcb_pkg::OFF_COUNT_LO, 16'hFFFE);
        wr(tcb_pkg::OFF_CTRL_B, 8'h01);
        repeat (8) @(posedge pclk);
        wr(tcb_pkg::OFF_CTRL_B, 8'h00);
        bus.get16(tcb_pkg::OFF_COUNT_LO, v);
        chk("wrap", 16'h0001, {15'h0000, v >= 16'h0006 && v < 16'h0020});
        rd(tcb_pkg::OFF_FLAG);
        chk("flags", 16'h0007, {8'h00, b});
        wr(tcb_pkg::OFF_MASK, 8'h02);
        repeat (3) @(posedge pclk);
        chk("irq_on", 16'h0001, {15'h0000, irq_req});
        wr(tcb_pkg::OFF_FLAG, 8'h02);
        repeat (3) @(posedge pclk);
        chk("irq_off", 16'h0000, {15'h0000, irq_req});
        wr(tcb_pkg::OFF_MASK, 8'h00);
        rd(tcb_pkg::OFF_FLAG);
        chk("flags", 16'h0005, {8'h00, b});
        wr(tcb_pkg::OFF_CTRL_B, 8'h01);
        bus.put16(tcb_pkg::OFF_COUNT_LO, 16'h8000);
        wr(tcb_pkg::OFF_CTRL_B, 8'h00);
        bus.get16(tcb_pkg::OFF_COUNT_LO, v);
        chk("over", 16'h0001, {15'h0000, v >= 16'h8000 && v < 16'h8010});
    endtask : t_run
    task t_ext;
        wr(tcb_pkg::OFF_FLAG, 8'hFF);
        bus.put16(tcb_pkg::OFF_COUNT_LO, 16'h0000);
        wr(tcb_pkg::OFF_CTRL_B, 8'h07);
        for (int i = 0; i < 5; i++) begin
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
        wr(tcb_pkg::OFF_CTRL_B, 8'h00);
        bus.get16(tcb_pkg::OFF_COUNT_LO, v);
        chk("ext", 16'h0005, v);
    endtask : t_ext
    task t_capture;
        wr(tcb_pkg::OFF_CTRL_B, 8'h41);
        repeat (2) @(posedge pclk);
        capture_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        wr(tcb_pkg::OFF_CTRL_B, 8'h00);
        rd(tcb_pkg::OFF_FLAG);
        chk("capt_flag", 16'h0008, {8'h00, b & 8'h08});
        bus.get16(tcb_pkg::OFF_CAPT_LO, v);
        chk("capt_val", 16'h0001, {15'h0000, v > 16'h0005});
    endtask : t_capture
    task t_misc;
        bus.put16(tcb_pkg::OFF_COUNT_LO, 16'h0100);
        wr(tcb_pkg::OFF_POWER, 8'h01);
        wr(tcb_pkg::OFF_CTRL_B, 8'h01);
        repeat (10) @(posedge pclk);
        bus.get16(tcb_pkg::OFF_COUNT_LO, v);
        chk("power", 16'h0100, v);
        wr(tcb_pkg::OFF_CTRL_B, 8'h00);
        wr(tcb_pkg::OFF_POWER, 8'h00);
        wr(tcb_pkg::OFF_CTRL_A, 8'h50);
        rd(tcb_pkg::OFF_CTRL_A);
        chk("ctrl_a", 16'h0050, {8'h00, b});
        wr(tcb_pkg::OFF_CTRL_A, 8'h00);
        rd(8'h40);
        chk("unmapped", 16'h0100, {7'h00, e, b});
    endtask : t_misc
    task t_wave;
        // Switching the capture source may fire a capture; cleared below
        wr(tcb_pkg::OFF_CTRL_A, 8'h54);
        bus.put16(tcb_pkg::OFF_COUNT_LO, 16'h0000);
        wr(tcb_pkg::OFF_FLAG, 8'hFF);
        wr(tcb_pkg::OFF_CTRL_B, 8'hC1);
        repeat (2) @(posedge pclk);
        comp_in <= 1'b1;
        repeat (8) @(posedge pclk);
        wr(tcb_pkg::OFF_CTRL_B, 8'h00);
        rd(tcb_pkg::OFF_FLAG);
        chk("filt_flags", 16'h000E, {8'h00, b});
        chk("outs", 16'h0003, {14'h0000, out_a, out_b});
    endtask : t_wave
    initial begin
        presetn = 1'b0;
        ext_clock_pin = 1'b0;
        capture_pin = 1'b0;
        comp_in = 1'b0;
        errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_shared();
        t_run();
        t_ext();
        t_capture();
        t_misc();
        t_wave();
        close_out();
    end
endmodule : test_tcb_timer16
